/* src/config_word_option_decode.v */
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "config_word_map.vh"

module config_word_option_decode (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        cfg_valid,
    output reg         cfg_ready,
    input  wire [31:0] cfg_data,
    output reg         core_release,
    output reg  [15:0] user_identifier,
    output reg         secondary_osc_high_power,
    output reg         debug_pin_pair_one,
    output reg         debug_pin_pair_two,
    output reg         debug_pin_pair_three,
    output reg         scan_port_enable,
    output reg         low_power_brownout_enable,
    output reg         retention_regulator_disable,
    output reg         brownout_hw_enable,
    output reg         brownout_active_only,
    output reg         brownout_software_ctrl,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    // ****************************************
    // Load sequencer
    // ****************************************
    localparam ST_LOAD = 2'h0;
    localparam ST_DONE = 2'h1;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [1:0]  index_reg;
    reg  [2:0]  rsvd_err_reg;
    reg  [31:0] devopt_reg;
    reg  [31:0] debug_reg;
    reg  [31:0] powerup_reg;
    wire        take;
    reg         rsvd_bad;

    assign take = cfg_valid && cfg_ready;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD: if (take && index_reg == `WORD_INDEX_POWERUP) state_next = ST_DONE;
            ST_DONE: state_next = ST_DONE;
            default: state_next = ST_LOAD;
        endcase
    end

    // Reserved-one checks; mismatches are flagged, never corrected
    always @* begin
        case (index_reg)
            `WORD_INDEX_DEVOPT: rsvd_bad = (cfg_data & `DEVOPT_RSVD_MASK) != `DEVOPT_RSVD_MASK;
            `WORD_INDEX_DEBUG:  rsvd_bad = (cfg_data & `DEBUG_RSVD_MASK) != `DEBUG_RSVD_MASK;
            default:            rsvd_bad = (cfg_data & `POWERUP_RSVD_MASK) != `POWERUP_RSVD_MASK;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= ST_LOAD;
            index_reg    <= `WORD_INDEX_DEVOPT;
            cfg_ready    <= 1'b0;
            core_release <= 1'b0;
            rsvd_err_reg <= 3'h0;
            devopt_reg   <= 32'h0000_0000;
            debug_reg    <= 32'h0000_0000;
            powerup_reg  <= 32'h0000_0000;
        end else begin
            state_reg    <= state_next;
            cfg_ready    <= (state_next == ST_LOAD);
            core_release <= (state_next == ST_DONE);
            if (take && state_reg == ST_LOAD) begin
                index_reg <= index_reg + 2'h1;
                rsvd_err_reg[index_reg] <= rsvd_bad;
                case (index_reg)
                    `WORD_INDEX_DEVOPT: devopt_reg  <= cfg_data;
                    `WORD_INDEX_DEBUG:  debug_reg   <= cfg_data;
                    default:            powerup_reg <= cfg_data;
                endcase
            end
        end
    end

    // ****************************************
    // Decoded options
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            user_identifier             <= 16'h0000;
            secondary_osc_high_power    <= 1'b0;
            debug_pin_pair_one          <= 1'b0;
            debug_pin_pair_two          <= 1'b0;
            debug_pin_pair_three        <= 1'b0;
            scan_port_enable            <= 1'b0;
            low_power_brownout_enable   <= 1'b0;
            retention_regulator_disable <= 1'b0;
            brownout_hw_enable          <= 1'b0;
            brownout_active_only        <= 1'b0;
            brownout_software_ctrl      <= 1'b0;
        end else if (state_reg == ST_LOAD && state_next == ST_DONE) begin
            user_identifier          <= devopt_reg[`USER_IDENTIFIER_MSB:`USER_IDENTIFIER_LSB];
            secondary_osc_high_power <= ~devopt_reg[`OSC_DRIVE_BIT];
            debug_pin_pair_one   <= debug_reg[`CHAN_MSB:`CHAN_LSB] == `CHAN_PAIR_ONE;
            debug_pin_pair_two   <= debug_reg[`CHAN_MSB:`CHAN_LSB] == `CHAN_PAIR_TWO;
            debug_pin_pair_three <= debug_reg[`CHAN_MSB:`CHAN_LSB] == `CHAN_PAIR_THREE;
            scan_port_enable     <= debug_reg[`SCAN_EN_BIT];
            low_power_brownout_enable   <= cfg_data[`LP_BOR_BIT];
            retention_regulator_disable <= cfg_data[`RET_VR_BIT];
            brownout_hw_enable     <= cfg_data[`BOR_MSB:`BOR_LSB] == `BOR_HW_ON;
            brownout_active_only   <= cfg_data[`BOR_MSB:`BOR_LSB] == `BOR_ACTIVE_ONLY;
            brownout_software_ctrl <= cfg_data[`BOR_MSB:`BOR_LSB] == `BOR_SOFTWARE;
        end
    end

    // ****************************************
    // Shadow copy for reads
    // ****************************************
    reg  [1:0]  rd_index;
    wire [31:0] store_rdata;

    config_word_store #(
        .DEPTH (3),
        .AW    (2)
    ) u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (take && state_reg == ST_LOAD),
        .wr_addr (index_reg),
        .wr_data (cfg_data),
        .rd_addr (rd_index),
        .rd_data (store_rdata)
    );

    // ****************************************
    // AXI4-Lite slave, read-only registers
    // ****************************************
    reg        rd_pend_reg;
    reg        rd_status_reg;
    reg        rd_bad_reg;
    reg        rd_live_reg;
    reg        aw_got_reg;
    reg        w_got_reg;

    always @* begin
        case (s_axi_araddr)
            `REG_DEBUG_ADDR:   rd_index = `WORD_INDEX_DEBUG;
            `REG_POWERUP_ADDR: rd_index = `WORD_INDEX_POWERUP;
            default:           rd_index = `WORD_INDEX_DEVOPT;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
            rd_pend_reg   <= 1'b0;
            rd_status_reg <= 1'b0;
            rd_bad_reg    <= 1'b0;
            rd_live_reg   <= 1'b0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !rd_pend_reg && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                rd_pend_reg   <= 1'b1;
                rd_status_reg <= s_axi_araddr == `REG_STATUS_ADDR;
                rd_live_reg   <= core_release;
                rd_bad_reg    <= s_axi_araddr != `REG_DEVOPT_ADDR && s_axi_araddr != `REG_DEBUG_ADDR &&
                                 s_axi_araddr != `REG_POWERUP_ADDR && s_axi_araddr != `REG_STATUS_ADDR;
            end else if (rd_pend_reg) begin
                rd_pend_reg  <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_bad_reg ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
                if (rd_bad_reg)
                    s_axi_rdata <= 32'h0000_0000;
                else if (rd_status_reg)
                    s_axi_rdata <= {28'h0000000, rsvd_err_reg, core_release};
                else if (!rd_live_reg)
                    s_axi_rdata <= 32'h0000_0000;
                else
                    s_axi_rdata <= store_rdata;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Writes are accepted and refused with SLVERR: all words are read-only
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !s_axi_awready && !aw_got_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_got_reg    <= 1'b1;
            end
            if (s_axi_wvalid && !s_axi_wready && !w_got_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_got_reg    <= 1'b1;
            end
            if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `AXI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
endmodule // config_word_option_decode

/* src/config_word_map.vh */
`ifndef CONFIG_WORD_MAP_VH
`define CONFIG_WORD_MAP_VH

`define REG_DEVOPT_ADDR      4'h0
`define REG_DEBUG_ADDR       4'h4
`define REG_POWERUP_ADDR     4'h8
`define REG_STATUS_ADDR      4'hc

`define WORD_INDEX_DEVOPT    2'h0
`define WORD_INDEX_DEBUG     2'h1
`define WORD_INDEX_POWERUP   2'h2
`define WORD_COUNT           3'h3

`define USER_IDENTIFIER_MSB           31
`define USER_IDENTIFIER_LSB           16
`define OSC_DRIVE_BIT        3
`define CHAN_MSB             4
`define CHAN_LSB             3
`define SCAN_EN_BIT          2
`define LP_BOR_BIT           3
`define RET_VR_BIT           2
`define BOR_MSB              1
`define BOR_LSB              0

`define DEVOPT_RSVD_MASK     32'h0000_fff7
`define DEBUG_RSVD_MASK      32'hffff_ffe3
`define POWERUP_RSVD_MASK    32'hffff_fff0

`define CHAN_PAIR_ONE        2'h3
`define CHAN_PAIR_TWO        2'h2
`define CHAN_PAIR_THREE      2'h1
`define CHAN_NONE            2'h0

`define BOR_HW_ON            2'h3
`define BOR_ACTIVE_ONLY      2'h2
`define BOR_SOFTWARE         2'h1
`define BOR_OFF              2'h0

`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

/* src/config_word_store.v */
`timescale 1ns/100ps
module config_word_store #(
    parameter DEPTH = 3,
    parameter AW    = 2
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [31:0]   wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [31:0]   rd_data
);
    reg [31:0] mem [0:DEPTH-1];

    always @(posedge aclk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    always @(posedge aclk) begin
        if (!aresetn)
            rd_data <= 32'h0000_0000;
        else
            rd_data <= mem[rd_addr];
    end
endmodule // config_word_store

/* dv/config_word_chk.sv */
`timescale 1ns/100ps
module config_word_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        cfg_valid,
    input wire        cfg_ready,
    input wire [31:0] cfg_data,
    input wire        core_release,
    input wire [15:0] user_identifier,
    input wire        secondary_osc_high_power,
    input wire        debug_pin_pair_one,
    input wire        debug_pin_pair_two,
    input wire        debug_pin_pair_three,
    input wire        scan_port_enable,
    input wire        brownout_hw_enable,
    input wire        brownout_active_only,
    input wire        brownout_software_ctrl
);
    // ****************
    // Load tracking
    // ****************
    reg  [1:0]  n_reg;
    reg  [95:0] w_reg;
    wire        take = cfg_valid && cfg_ready;
    wire        last = take && n_reg == 2'h2;
    wire [2:0]  pairs = {debug_pin_pair_one, debug_pin_pair_two, debug_pin_pair_three};
    wire [2:0]  bor = {brownout_hw_enable, brownout_active_only, brownout_software_ctrl};
    always @(posedge aclk) begin
        n_reg <= aresetn ? n_reg + {1'b0, take} : 2'h0;
        if (take) w_reg <= {cfg_data, w_reg[95:32]};
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    uid_load_a: assert property (last |=> core_release && user_identifier == w_reg[31:16])
        else $error("user id not loaded");
    osc_drive_a: assert property (last |=> secondary_osc_high_power == !w_reg[3])
        else $error("oscillator drive wrong");
    chan_sel_a: assert property (last |=> {1'b0, pairs} == (4'h1 << w_reg[36:35]) >> 1)
        else $error("debug pair wrong");
    pair_onehot_a: assert property ($onehot0(pairs))
        else $error("debug pairs not exclusive");
    scan_en_a: assert property (last |=> scan_port_enable == w_reg[34])
        else $error("scan enable wrong");
    bor_mode_a: assert property (last |=> {1'b0, bor} == (4'h1 << w_reg[65:64]) >> 1)
        else $error("brown-out mode wrong");
    hold_out_a: assert property (core_release |=> core_release && !cfg_ready && $stable({user_identifier, pairs, bor}))
        else $error("outputs moved after load");
    zero_early_a: assert property (!core_release |-> user_identifier == 16'h0 && pairs == 3'h0 && bor == 3'h0)
        else $error("outputs set before load");
    cover property (last);
    cover property (core_release && debug_pin_pair_two);
    cover property (core_release && brownout_software_ctrl);
endmodule // config_word_chk

/* dv/config_word_option_decode_tb.sv */
`timescale 1ns/100ps
`include "config_word_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module config_word_option_decode_tb;
    reg         aclk = 1'b0, aresetn = 1'b0, cfg_valid = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg  [31:0] cfg_data = 32'h0, s_axi_wdata = 32'h0, d, seed = 32'hd3d93983;
    reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    reg  [1:0]  r;
    reg  [95:0] w;
    wire        cfg_ready, core_release, secondary_osc_high_power, scan_port_enable, s_axi_awready;
    wire        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, brownout_hw_enable;
    wire        brownout_active_only, brownout_software_ctrl, low_power_brownout_enable;
    wire        retention_regulator_disable, debug_pin_pair_one, debug_pin_pair_two, debug_pin_pair_three;
    wire [15:0] user_identifier;
    wire [31:0] s_axi_rdata;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [2:0]  pairs = {debug_pin_pair_one, debug_pin_pair_two, debug_pin_pair_three};
    wire [4:0]  bor = {low_power_brownout_enable, retention_regulator_disable, brownout_hw_enable,
                       brownout_active_only, brownout_software_ctrl};
    integer     n_fail = 0, n_compared = 0, cyc = 0, i, k;
    config_word_option_decode u_dut (.*);
    // ****************
    // Helpers and bus tasks
    // ****************
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [2:0] dec3(input [1:0] c);
        dec3 = (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
    endfunction
    task close_out;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) if (++cyc == 2000) begin
        n_fail++;
        close_out;
    end
    task rd(input [3:0] a, output [31:0] v, output [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task wr(input [3:0] a, input [31:0] v, output [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task load(input [95:0] v);
        integer j;
        @(posedge aclk);
        cfg_valid <= 1'b1;
        for (j = 0; j < 3; j++) begin
            cfg_data <= v[32*j +: 32];
            do @(posedge aclk); while (cfg_ready !== 1'b1);
        end
        cfg_valid <= 1'b0;
    endtask
    initial begin
        for (i = 0; i < 4; i++) begin
            aresetn <= 1'b0;
            repeat (4) @(posedge aclk);
            aresetn <= 1'b1;
            seed = lfsr(seed);
            w[31:0] = {seed[31:16], 12'hfff, seed[5], 2'h3, i != 0};
            w[63:32] = {27'h7ffffff, i[1:0], seed[7], 2'h3};
            w[95:64] = {28'hfffffff, seed[9:8], i[1:0]};
            rd(`REG_DEVOPT_ADDR, d, r);
            `CHK({r, d}, {`AXI_RESP_OKAY, 32'h0})
            load(w);
            wr(`REG_DEVOPT_ADDR, ~w[31:0], r);
            `CHK(r, `AXI_RESP_SLVERR)
            rd(4'h2, d, r);
            `CHK({r, d}, {`AXI_RESP_SLVERR, 32'h0})
            cfg_valid <= 1'b1;
            cfg_data <= ~w[31:0];
            repeat (3) @(posedge aclk);
            cfg_valid <= 1'b0;
            `CHK({cfg_ready, core_release}, 2'h1)
            `CHK(user_identifier, w[31:16])
            `CHK(secondary_osc_high_power, ~w[3])
            `CHK(pairs, dec3(w[36:35]))
            `CHK(scan_port_enable, w[34])
            `CHK(bor, {w[67:66], dec3(w[65:64])})
            for (k = 0; k < 4; k++) begin
                rd({k[1:0], 2'h0}, d, r);
                `CHK({r, d}, {`AXI_RESP_OKAY, k == 3 ? {30'h0, i == 0, 1'b1} : w[32*(k%3) +: 32]})
            end
            $display("test %0d done", i);
        end
        close_out;
    end
endmodule // config_word_option_decode_tb
bind config_word_option_decode config_word_chk u_chk (
    .aclk                     (aclk),
    .aresetn                  (aresetn),
    .cfg_valid                (cfg_valid),
    .cfg_ready                (cfg_ready),
    .cfg_data                 (cfg_data),
    .core_release             (core_release),
    .user_identifier          (user_identifier),
    .secondary_osc_high_power (secondary_osc_high_power),
    .debug_pin_pair_one       (debug_pin_pair_one),
    .debug_pin_pair_two       (debug_pin_pair_two),
    .debug_pin_pair_three     (debug_pin_pair_three),
    .scan_port_enable         (scan_port_enable),
    .brownout_hw_enable       (brownout_hw_enable),
    .brownout_active_only     (brownout_active_only),
    .brownout_software_ctrl   (brownout_software_ctrl)
);
